// [pwm_underflow_consts.svh]
`ifndef PWM_UNDERFLOW_CONSTS_SVH
`define PWM_UNDERFLOW_CONSTS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define CNT_W          10
`define BYTE_W         8
`define HIGH_W         2
`define IDX_W          10
`define IDX_LSB        2

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_PERIOD_LOW  10'h0D9
`define IDX_LEVEL_LOW   10'h0DA
`define IDX_CONTROL     10'h0DC
`define IDX_IRQ_ENABLE  10'h0E8
`define IDX_IRQ_HIPRI   10'h0F7
`define IDX_PERIOD_HIGH 10'h040
`define IDX_LEVEL_HIGH  10'h041
`define IDX_IRQ_STATUS  10'h042
`define IDX_IRQ_MASK    10'h043
`define IDX_COUNT_VIEW  10'h044

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_RUN        7
`define BIT_RELOAD     6
`define BIT_FLAG       5
`define BIT_CLEAR      4
`define BIT_INVERT     0
`define BIT_UF_ENABLE  5
`define BIT_UF_TOP     5
`define BIT_UF_STATUS  0

// ----------------------------------------
// Masks, reset values, responses
// ----------------------------------------
`define CTRL_MASK      8'hF1
`define IRQ_BITS_MASK  8'h70
`define REG_RST        8'h00
`define IRQ_MASK_RST   8'h01
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// [pwm_underflow_pkg.sv]
`include "pwm_underflow_consts.svh"

package pwm_underflow_pkg;
   typedef logic [`CNT_W-1:0]  count_t;
   typedef logic [`BYTE_W-1:0] byte_t;
   typedef logic [`IDX_W-1:0]  reg_idx_t;
   typedef enum logic [1:0] {
      WR_COLLECT = 2'b01,
      WR_RESP    = 2'b10
   } wr_state_t;
endpackage : pwm_underflow_pkg

// [pwm_down_counter.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pwm_underflow_consts.svh"

module pwm_down_counter
   import pwm_underflow_pkg::*;
#(
   parameter int CNT_W = `CNT_W
)(
   input  wire logic             mclk,
   input  wire logic             reset,
   input  wire logic             run,
   input  wire logic             clear,
   input  wire logic             reload,
   input  wire logic [CNT_W-1:0] period,
   output logic      [CNT_W-1:0] count,
   output logic                  underflow
);

   if (CNT_W < 2) begin : g_chk
      $error("pwm_down_counter: CNT_W must be at least 2");
   end

   logic [CNT_W-1:0] next_count;

   // Underflow is the step from zero while running
   assign underflow = run && !clear && (count == '0);

   // Next count: clear first, then run, load or wrap
   always_comb begin
      next_count = count;
      if (clear) begin
         next_count = '0;                            // see RL5
      end else if (run) begin                        // see RL1
         if (count == '0) begin
            next_count = reload ? period : '1;       // see RL2, see RL3
         end else begin
            next_count = count - 1'b1;
         end
      end
   end

   // Counter register
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

endmodule : pwm_down_counter

`default_nettype wire

// [pwm_out_stage.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pwm_underflow_consts.svh"

module pwm_out_stage
   import pwm_underflow_pkg::*;
#(
   parameter int CNT_W = `CNT_W
)(
   input  wire logic             mclk,
   input  wire logic             reset,
   input  wire logic             load,
   input  wire logic [CNT_W-1:0] level_buf,
   input  wire logic [CNT_W-1:0] count,
   input  wire logic             invert,
   output logic                  pwm_out
);

   if (CNT_W < 2) begin : g_chk
      $error("pwm_out_stage: CNT_W must be at least 2");
   end

   logic [CNT_W-1:0] work_level;
   logic [CNT_W-1:0] next_work_level;
   logic             next_pwm_out;

   // Working level only follows the buffer on a reload
   always_comb begin
      next_work_level = load ? level_buf : work_level;   // see RL3
      next_pwm_out    = (count < work_level) ^ invert;    // see RL6
   end

   // Working level and output register
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         work_level <= '0;
         pwm_out    <= 1'b0;
      end else begin
         work_level <= next_work_level;
         pwm_out    <= next_pwm_out;
      end
   end

   invert_out_a : assert property (@(posedge mclk) disable iff (reset)   // see RL6
      1'b1 |=> pwm_out == (($past(count) < $past(work_level)) ^ $past(invert)))
      else $error("output polarity does not follow invert bit");

   level_hold_a : assert property (@(posedge mclk) disable iff (reset)   // see RL3
      !load |=> $stable(work_level))
      else $error("working level changed without reload");

endmodule : pwm_out_stage

`default_nettype wire

// [pwm_underflow_control.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pwm_underflow_consts.svh"

// Summary of operation
// RL1 - Counter steps down only while the run bit is one.
// RL2 - With reload set, underflow loads the period; reload bit self-clears two cycles after the underflow.
// RL3 - With reload clear, period and level buffers never reach working registers.
// RL4 - Underflow of the 10-bit counter sets the flag and requests an interrupt.
// RL5 - Writing one to the clear bit zeroes the counter; the bit self-clears.
// RL6 - Invert bit zero gives normal output, one gives inverted output.
// RL7 - Read-write byte holds low eight bits of the channel-0 level.
// RL8 - Top-priority bit raises the underflow interrupt to highest priority.
// RL9 - Byte register holds low bits of the period reloaded into the counter.
// RL10 - Underflow interrupt reaches the processor only while its enable bit is one.
module pwm_underflow_control
   import pwm_underflow_pkg::*;
#(
   parameter int ADDR_W = 12
)(
   input  wire logic              mclk,
   input  wire logic              reset,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic                   pwm_out,
   output logic                   irq,
   output logic                   irq_top
);

   if (ADDR_W < `IDX_W + `IDX_LSB) begin : g_chk
      $error("pwm_underflow_control: ADDR_W too small for register map");
   end

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   wr_state_t  wr_state;
   wr_state_t  next_wr_state;
   logic       aw_held;
   logic       next_aw_held;
   logic       w_held;
   logic       next_w_held;
   reg_idx_t   aw_idx;
   reg_idx_t   next_aw_idx;
   byte_t      wd;
   byte_t      next_wd;
   logic       wlane0;
   logic       next_wlane0;
   logic       next_awready;
   logic       next_wready;
   logic       next_bvalid;
   logic [1:0] next_bresp;
   logic       wr_fire;
   logic       wr_en;
   logic       wr_hit;

   logic        next_arready;
   logic        next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0]  next_rresp;
   reg_idx_t    rd_idx;
   logic [31:0] rd_word;
   logic        rd_hit;

   byte_t              ctrl;
   byte_t              next_ctrl;
   byte_t              level_low;
   byte_t              next_level_low;
   byte_t              period_low;
   byte_t              next_period_low;
   logic [`HIGH_W-1:0] level_high;
   logic [`HIGH_W-1:0] next_level_high;
   logic [`HIGH_W-1:0] period_high;
   logic [`HIGH_W-1:0] next_period_high;
   byte_t              irq_en;
   byte_t              next_irq_en;
   byte_t              irq_hipri;
   byte_t              next_irq_hipri;
   logic               reload_taken;
   logic               next_reload_taken;

   byte_t irq_status;
   byte_t next_irq_status;
   byte_t irq_mask;
   byte_t next_irq_mask;
   logic  next_irq;
   logic  next_irq_top;

   count_t count;
   logic   underflow;
   count_t period;
   count_t level_buf;

   // ----------------------------------------
   // Write channel
   // ----------------------------------------

   // A write lands once both address and data are held
   assign wr_fire = (wr_state == WR_COLLECT) && aw_held && w_held;
   assign wr_en   = wr_fire && wlane0;

   // Write address decode
   always_comb begin
      case (aw_idx)
         `IDX_PERIOD_LOW, `IDX_LEVEL_LOW, `IDX_CONTROL,
         `IDX_IRQ_ENABLE, `IDX_IRQ_HIPRI, `IDX_PERIOD_HIGH,
         `IDX_LEVEL_HIGH, `IDX_IRQ_STATUS, `IDX_IRQ_MASK,
         `IDX_COUNT_VIEW: wr_hit = 1'b1;
         default:         wr_hit = 1'b0;
      endcase
   end

   // Next state of the write channel
   always_comb begin
      next_wr_state = wr_state;
      next_aw_held  = aw_held;
      next_w_held   = w_held;
      next_aw_idx   = aw_idx;
      next_wd       = wd;
      next_wlane0   = wlane0;
      next_bvalid   = s_axi_bvalid;
      next_bresp    = s_axi_bresp;
      case (wr_state)
         WR_COLLECT: begin
            if (s_axi_awvalid && s_axi_awready) begin
               next_aw_held = 1'b1;
               next_aw_idx  = s_axi_awaddr[`IDX_W+`IDX_LSB-1:`IDX_LSB];
            end
            if (s_axi_wvalid && s_axi_wready) begin
               next_w_held = 1'b1;
               next_wd     = s_axi_wdata[`BYTE_W-1:0];
               next_wlane0 = s_axi_wstrb[0];
            end
            if (wr_fire) begin
               next_aw_held  = 1'b0;
               next_w_held   = 1'b0;
               next_bvalid   = 1'b1;
               next_bresp    = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
               next_wr_state = WR_RESP;
            end
         end
         WR_RESP: begin
            if (s_axi_bready) begin
               next_bvalid   = 1'b0;
               next_wr_state = WR_COLLECT;
            end
         end
         default: begin
            next_wr_state = WR_COLLECT;
         end
      endcase
      next_awready = (next_wr_state == WR_COLLECT) && !next_aw_held;
      next_wready  = (next_wr_state == WR_COLLECT) && !next_w_held;
   end

   // Write channel registers
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         wr_state      <= WR_COLLECT;
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_idx        <= '0;
         wd            <= '0;
         wlane0        <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
      end else begin
         wr_state      <= next_wr_state;
         aw_held       <= next_aw_held;
         w_held        <= next_w_held;
         aw_idx        <= next_aw_idx;
         wd            <= next_wd;
         wlane0        <= next_wlane0;
         s_axi_awready <= next_awready;
         s_axi_wready  <= next_wready;
         s_axi_bvalid  <= next_bvalid;
         s_axi_bresp   <= next_bresp;
      end
   end

   // ----------------------------------------
   // Read channel
   // ----------------------------------------

   assign rd_idx = s_axi_araddr[`IDX_W+`IDX_LSB-1:`IDX_LSB];

   // Read data selection
   always_comb begin
      rd_word = '0;
      rd_hit  = 1'b1;
      case (rd_idx)
         `IDX_PERIOD_LOW:  rd_word[`BYTE_W-1:0] = period_low;  // see RL9
         `IDX_LEVEL_LOW:   rd_word[`BYTE_W-1:0] = level_low;   // see RL7
         `IDX_CONTROL:     rd_word[`BYTE_W-1:0] = ctrl;
         `IDX_IRQ_ENABLE:  rd_word[`BYTE_W-1:0] = irq_en;
         `IDX_IRQ_HIPRI:   rd_word[`BYTE_W-1:0] = irq_hipri;
         `IDX_PERIOD_HIGH: rd_word[`HIGH_W-1:0] = period_high;
         `IDX_LEVEL_HIGH:  rd_word[`HIGH_W-1:0] = level_high;
         `IDX_IRQ_STATUS:  rd_word[`BYTE_W-1:0] = irq_status;
         `IDX_IRQ_MASK:    rd_word[`BYTE_W-1:0] = irq_mask;
         `IDX_COUNT_VIEW:  rd_word[`CNT_W-1:0]  = count;
         default:          rd_hit = 1'b0;
      endcase
   end

   // Next state of the read channel
   always_comb begin
      next_arready = s_axi_arready;
      next_rvalid  = s_axi_rvalid;
      next_rdata   = s_axi_rdata;
      next_rresp   = s_axi_rresp;
      if (s_axi_arvalid && s_axi_arready) begin
         next_arready = 1'b0;
         next_rvalid  = 1'b1;
         next_rdata   = rd_word;
         next_rresp   = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         next_arready = 1'b1;
         next_rvalid  = 1'b0;
      end else if (!s_axi_rvalid) begin
         next_arready = 1'b1;
      end
   end

   // Read channel registers
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= `RESP_OKAY;
      end else begin
         s_axi_arready <= next_arready;
         s_axi_rvalid  <= next_rvalid;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rresp;
      end
   end

   // ----------------------------------------
   // Control and value registers
   // ----------------------------------------

   // Clear bit drops, then software writes, then hardware clears reload and sets flag
   always_comb begin
      next_ctrl         = ctrl;
      next_level_low    = level_low;
      next_period_low   = period_low;
      next_level_high   = level_high;
      next_period_high  = period_high;
      next_irq_en       = irq_en;
      next_irq_hipri    = irq_hipri;
      next_reload_taken = underflow && ctrl[`BIT_RELOAD];
      next_ctrl[`BIT_CLEAR] = 1'b0;                                // see RL5
      if (wr_en) begin
         case (aw_idx)
            `IDX_CONTROL: begin
               next_ctrl = wd & `CTRL_MASK;
               next_ctrl[`BIT_FLAG] = wd[`BIT_FLAG] & ctrl[`BIT_FLAG];
            end
            `IDX_LEVEL_LOW:   next_level_low   = wd;              // see RL7
            `IDX_PERIOD_LOW:  next_period_low  = wd;              // see RL9
            `IDX_LEVEL_HIGH:  next_level_high  = wd[`HIGH_W-1:0];
            `IDX_PERIOD_HIGH: next_period_high = wd[`HIGH_W-1:0];
            `IDX_IRQ_ENABLE:  next_irq_en      = wd & `IRQ_BITS_MASK;
            `IDX_IRQ_HIPRI:   next_irq_hipri   = wd & `IRQ_BITS_MASK;
            default: begin
            end
         endcase
      end
      if (reload_taken) begin
         next_ctrl[`BIT_RELOAD] = 1'b0;                           // see RL2
      end
      if (underflow) begin
         next_ctrl[`BIT_FLAG] = 1'b1;                             // see RL4
      end
   end

   // Control registers
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ctrl         <= `REG_RST;
         level_low    <= `REG_RST;
         period_low   <= `REG_RST;
         level_high   <= '0;
         period_high  <= '0;
         irq_en       <= `REG_RST;
         irq_hipri    <= `REG_RST;
         reload_taken <= 1'b0;
      end else begin
         ctrl         <= next_ctrl;
         level_low    <= next_level_low;
         period_low   <= next_period_low;
         level_high   <= next_level_high;
         period_high  <= next_period_high;
         irq_en       <= next_irq_en;
         irq_hipri    <= next_irq_hipri;
         reload_taken <= next_reload_taken;
      end
   end

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------

   // Sticky status, set wins over write-one-to-clear
   always_comb begin
      next_irq_status = irq_status;
      next_irq_mask   = irq_mask;
      if (wr_en && aw_idx == `IDX_IRQ_STATUS) begin
         next_irq_status = irq_status & ~wd;
      end
      if (wr_en && aw_idx == `IDX_IRQ_MASK) begin
         next_irq_mask = wd;
      end
      if (underflow) begin
         next_irq_status[`BIT_UF_STATUS] = 1'b1;                  // see RL4
      end
      next_irq       = (|(irq_status & irq_mask))
                       && irq_en[`BIT_UF_ENABLE];                 // see RL10
      next_irq_top   = next_irq && irq_hipri[`BIT_UF_TOP];        // see RL8
   end

   // Interrupt registers
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         irq_status <= `REG_RST;
         irq_mask   <= `IRQ_MASK_RST;
         irq        <= 1'b0;
         irq_top    <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq_mask   <= next_irq_mask;
         irq        <= next_irq;
         irq_top    <= next_irq_top;
      end
   end

   // ----------------------------------------
   // Counter and output stage
   // ----------------------------------------

   assign period    = {period_high, period_low};
   assign level_buf = {level_high, level_low};

   pwm_down_counter #(.CNT_W(`CNT_W)) u_counter (
      .mclk      (mclk),
      .reset     (reset),
      .run       (ctrl[`BIT_RUN]),
      .clear     (ctrl[`BIT_CLEAR]),
      .reload    (ctrl[`BIT_RELOAD]),
      .period    (period),
      .count     (count),
      .underflow (underflow)
   );

   pwm_out_stage #(.CNT_W(`CNT_W)) u_out (
      .mclk      (mclk),
      .reset     (reset),
      .load      (underflow && ctrl[`BIT_RELOAD]),
      .level_buf (level_buf),
      .count     (count),
      .invert    (ctrl[`BIT_INVERT]),
      .pwm_out   (pwm_out)
   );

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   sequence s_uf_reload;
      underflow && ctrl[`BIT_RELOAD];
   endsequence

   sequence s_uf_wrap;
      underflow && !ctrl[`BIT_RELOAD];
   endsequence

   run_hold_a : assert property (                                  // see RL1
      !ctrl[`BIT_RUN] && !ctrl[`BIT_CLEAR] |=> count == $past(count))
      else $error("counter moved while stopped");

   reload_load_a : assert property (                               // see RL2
      s_uf_reload |=> count == $past(period))
      else $error("period not loaded on underflow");

   reload_clear_a : assert property (                              // see RL2
      s_uf_reload |=> ##1 !ctrl[`BIT_RELOAD])
      else $error("reload bit not cleared by hardware");

   wrap_noload_a : assert property (                               // see RL3
      s_uf_wrap |=> count == '1)
      else $error("period loaded without reload bit");

   flag_set_a : assert property (                                  // see RL4
      underflow |=> ctrl[`BIT_FLAG] && irq_status[`BIT_UF_STATUS])
      else $error("underflow flag not set");

   clear_zero_a : assert property (                                // see RL5
      ctrl[`BIT_CLEAR] && !(wr_en && aw_idx == `IDX_CONTROL)
      |=> count == '0 && !ctrl[`BIT_CLEAR])
      else $error("counter clear failed");

   level_write_a : assert property (                               // see RL7
      wr_en && aw_idx == `IDX_LEVEL_LOW |=> level_low == $past(wd))
      else $error("level low byte not written");

   period_write_a : assert property (                              // see RL9
      wr_en && aw_idx == `IDX_PERIOD_LOW |=> period_low == $past(wd))
      else $error("period low byte not written");

   irq_gate_a : assert property (                                  // see RL10
      !irq_en[`BIT_UF_ENABLE] |=> !irq)
      else $error("interrupt raised while disabled");

   top_prio_a : assert property (                                  // see RL8
      irq_top |-> irq && $past(irq_hipri[`BIT_UF_TOP]))
      else $error("top priority without enable bit");

endmodule : pwm_underflow_control

`default_nettype wire

// [pwm_load.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Load on the modulator pin
// ----------------------------------------
module pwm_load (
   input  wire logic mclk,
   input  wire logic pin,
   output logic      seen
);
   // Load settles to the pin level one clock later
   always_ff @(posedge mclk) begin
      seen <= pin;
   end
endmodule : pwm_load
`default_nettype wire

// [pwm_underflow_control_test.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pwm_underflow_consts.svh"

module pwm_underflow_control_test import pwm_underflow_pkg::*;;
   logic        mclk, reset, seen;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pwm_out, irq, irq_top;
   count_t      c0;
   int          fail_count, cmp_count;

   pwm_underflow_control DUT (.mclk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwm_out,
      .irq, .irq_top);
   pwm_load load (.mclk, .pin(pwm_out), .seen);

   // ----------------------------------------
   // Compare, report and bus tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic final_report;
      $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report

   // Bounded wait: a stuck handshake ends the run
   task automatic hang(input int n);
      if (n > 200) begin
         fail_count++;
         final_report();
      end
   endtask : hang

   task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] resp);
      int n;
      @(posedge mclk);
      s_axi_awaddr  <= {idx, 2'b00};
      s_axi_wdata   <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
         hang(n);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, s_axi_bresp}, {30'h0, resp});
   endtask : wr

   task automatic rd_reg(input logic [9:0] idx, input logic [1:0] resp, output logic [31:0] d);
      int n;
      @(posedge mclk);
      s_axi_araddr  <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
         hang(n);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
      chk("rresp", {30'h0, s_axi_rresp}, {30'h0, resp});
   endtask : rd_reg

   task automatic rc(input string what, input logic [9:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      rd_reg(idx, `RESP_OKAY, d);
      chk(what, d, exp);
   endtask : rc

   // Clock at 50 MHz
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      fail_count = 0;
      cmp_count = 0;
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      rc("control reset", `IDX_CONTROL, 32'h00);
      rc("mask reset", `IDX_IRQ_MASK, 32'h01);
      wr(`IDX_LEVEL_LOW, 8'hA5, `RESP_OKAY);
      rc("level_low", `IDX_LEVEL_LOW, 32'hA5);
      wr(`IDX_PERIOD_LOW, 8'h5A, `RESP_OKAY);
      rc("period_low", `IDX_PERIOD_LOW, 32'h5A);
      // A write with lane 0 off is answered but changes nothing
      s_axi_wstrb <= 4'h0;
      wr(`IDX_LEVEL_LOW, 8'h3C, `RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      rc("level no strobe", `IDX_LEVEL_LOW, 32'hA5);
      wr(`IDX_IRQ_ENABLE, 8'hFF, `RESP_OKAY);
      rc("irq_enable", `IDX_IRQ_ENABLE, 32'h70);
      wr(`IDX_IRQ_HIPRI, 8'hFF, `RESP_OKAY);
      rc("irq_hipri", `IDX_IRQ_HIPRI, 32'h70);
      wr(`IDX_CONTROL, 8'h0E, `RESP_OKAY);
      rc("control reserved", `IDX_CONTROL, 32'h00);
      wr(10'h100, 8'h01, `RESP_SLVERR);
      rd_reg(10'h100, `RESP_SLVERR, rd);
      chk("unmapped data", rd, 32'h0);
      $display("Test registers done");
      // Run without reload: underflow wraps to the top, not the period
      wr(`IDX_CONTROL, 8'h80, `RESP_OKAY);
      repeat (20) @(posedge mclk);
      wr(`IDX_CONTROL, 8'h00, `RESP_OKAY);
      rd_reg(`IDX_COUNT_VIEW, `RESP_OKAY, rd);
      c0 = rd[9:0];
      chk("wrapped count", {31'h0, c0 > 10'h380}, 32'h1);
      repeat (10) @(posedge mclk);
      rc("stopped count", `IDX_COUNT_VIEW, {22'h0, c0});
      wr(`IDX_CONTROL, 8'h10, `RESP_OKAY);
      rc("clear bit", `IDX_CONTROL, 32'h00);
      rc("cleared count", `IDX_COUNT_VIEW, 32'h0);
      $display("Test run and clear done");
      // Reload the period at underflow with the interrupt enabled
      wr(`IDX_LEVEL_LOW, 8'hFF, `RESP_OKAY);
      wr(`IDX_LEVEL_HIGH, 8'h03, `RESP_OKAY);
      wr(`IDX_PERIOD_LOW, 8'h04, `RESP_OKAY);
      wr(`IDX_PERIOD_HIGH, 8'h01, `RESP_OKAY);
      wr(`IDX_CONTROL, 8'hC0, `RESP_OKAY);
      rc("reload done", `IDX_CONTROL, 32'hA0);
      wr(`IDX_CONTROL, 8'h20, `RESP_OKAY);
      rd_reg(`IDX_COUNT_VIEW, `RESP_OKAY, rd);
      chk("reloaded count", {31'h0, rd[9:0] <= 10'h104 && rd[9:0] > 10'h0E0}, 32'h1);
      rc("status", `IDX_IRQ_STATUS, 32'h01);
      chk("irq", {31'h0, irq}, 32'h1);
      chk("irq_top", {31'h0, irq_top}, 32'h1);
      chk("pin normal", {31'h0, seen}, 32'h1);
      wr(`IDX_CONTROL, 8'h21, `RESP_OKAY);
      repeat (3) @(posedge mclk);
      chk("pin inverted", {31'h0, seen}, 32'h0);
      $display("Test reload and output done");
      // Mask, enable and clear of the interrupt
      wr(`IDX_IRQ_MASK, 8'h00, `RESP_OKAY);
      repeat (2) @(posedge mclk);
      chk("irq masked", {31'h0, irq}, 32'h0);
      wr(`IDX_IRQ_MASK, 8'h01, `RESP_OKAY);
      wr(`IDX_IRQ_ENABLE, 8'h00, `RESP_OKAY);
      repeat (2) @(posedge mclk);
      chk("irq disabled", {31'h0, irq}, 32'h0);
      chk("irq_top disabled", {31'h0, irq_top}, 32'h0);
      wr(`IDX_IRQ_ENABLE, 8'h20, `RESP_OKAY);
      repeat (2) @(posedge mclk);
      chk("irq enabled", {31'h0, irq}, 32'h1);
      wr(`IDX_IRQ_STATUS, 8'h01, `RESP_OKAY);
      rc("status cleared", `IDX_IRQ_STATUS, 32'h00);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      wr(`IDX_CONTROL, 8'h01, `RESP_OKAY);
      rc("flag cleared", `IDX_CONTROL, 32'h01);
      $display("Test interrupt done");
      // Reset with the counter stopped returns the registers and interrupt outputs to reset values
      reset <= 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      rc("level after reset", `IDX_LEVEL_LOW, 32'h00);
      rc("control after reset", `IDX_CONTROL, 32'h00);
      rc("mask after reset", `IDX_IRQ_MASK, 32'h01);
      chk("irq after reset", {31'h0, irq}, 32'h0);
      chk("irq_top after reset", {31'h0, irq_top}, 32'h0);
      $display("Test reset done");
      final_report();
   end
endmodule : pwm_underflow_control_test
`default_nettype wire
